// >>> logic/rtcca_top.sv
// rtcca_top: clock timebase with calibration, alarm engine and registers
`timescale 1ns/1ps
module rtcca_top
	import rtcca_pkg::*;
(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [rtcca_pkg::ADDR_W-1:0] paddr,
	input  wire logic [rtcca_pkg::DATA_W-1:0] pwdata,
	output logic      [rtcca_pkg::DATA_W-1:0] prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         xtal_clk_pin,
	output logic                              alarm_irq,
	output logic                              alarm_pulse
);
	typedef struct packed {
		logic                     timer_on;
		logic [7:0]               cal;
		logic                     alarm_enable;
		logic                     indefinite_repeat;
		rtcca_alarm_match_mask_t             alarm_match_mask;
		logic [7:0]               alarm_repeat_count;
		rtcca_time_t              now;
		rtcca_time_t              alarm_compare_value;
		logic signed [PRE_W-1:0]  presc;
		logic                     half_ev;
		logic                     full_ev;
		logic [EV_N-1:0]          stat;
		logic [EV_N-1:0]          mask;
		logic                     rollover_sync_status;
		logic                     irq;
		logic                     pulse;
	} rtcca_st_t;

	localparam rtcca_st_t ST_RESET = '{
		now:                 TIME_RESET,
		alarm_compare_value: TIME_RESET,
		default:             '0
	};

	rtcca_st_t   st_ff;
	rtcca_st_t   nxt_st;
	logic        xtal_tick;
	rtcca_reg_if rbus ();

	rtcca_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rbus    (rbus)
	);

	rtcca_xtal_sync u_xtal (
		.pclk     (pclk),
		.presetn  (presetn),
		.xtal_pin (xtal_clk_pin),
		.tick     (xtal_tick)
	);

	function automatic logic [5:0] units(input logic [5:0] v);
		return v % DIGIT_10;
	endfunction

	function automatic logic [4:0] month_len(input logic [3:0] mon, input logic [6:0] year);
		logic leap;
		leap = (year[1:0] == 2'h0);
		case (mon)
			4'h2: month_len = leap ? DAY_29 : DAY_28;
			4'h4, 4'h6, 4'h9, 4'hB: month_len = DAY_30;
			default: month_len = DAY_31;
		endcase
	endfunction

	// one-second advance of the calendar
	function automatic rtcca_time_t advance(input rtcca_time_t t);
		rtcca_time_t n;
		n = t;
		if (t.sec != SEC_LAST) begin
			n.sec = t.sec + 6'h01;
		end else begin
			n.sec = '0;
			if (t.min != MIN_LAST) begin
				n.min = t.min + 6'h01;
			end else begin
				n.min = '0;
				if (t.hour != HOUR_LAST) begin
					n.hour = t.hour + 5'h01;
				end else begin
					n.hour = '0;
					n.wday = (t.wday == WDAY_LAST) ? 3'h0 : t.wday + 3'h1;
					if (t.day != month_len(t.mon, t.year)) begin
						n.day = t.day + 5'h01;
					end else begin
						n.day = 5'h01;
						if (t.mon != MON_LAST) begin
							n.mon = t.mon + 4'h1;
						end else begin
							n.mon  = 4'h1;
							n.year = (t.year == YEAR_LAST) ? 7'h00 : t.year + 7'h01;
						end
					end
				end
			end
		end
		return n;
	endfunction

	// digits selected by the mask must all agree
	function automatic logic alarm_match(input rtcca_alarm_match_mask_t m, input rtcca_time_t n,
			input rtcca_time_t a);
		logic s10;
		logic s;
		logic m10;
		logic mi;
		logic h;
		s10 = units(n.sec) == units(a.sec);
		s   = n.sec == a.sec;
		m10 = s & (units(n.min) == units(a.min));
		mi  = s & (n.min == a.min);
		h   = mi & (n.hour == a.hour);
		case (m)
			MSK_HALF, MSK_SEC: alarm_match = 1'b1;
			MSK_10SEC: alarm_match = s10;
			MSK_MIN:   alarm_match = s;
			MSK_10MIN: alarm_match = m10;
			MSK_HOUR:  alarm_match = mi;
			MSK_DAY:   alarm_match = h;
			MSK_WEEK:  alarm_match = h & (n.wday == a.wday);
			MSK_MONTH: alarm_match = h & (n.day == a.day);
			MSK_YEAR:  alarm_match = h & (n.day == a.day) & (n.mon == a.mon);
			default:   alarm_match = 1'b0;
		endcase
	endfunction

	function automatic logic [DATA_W-1:0] time_word(input rtcca_time_t t);
		logic [DATA_W-1:0] w;
		w = '0;
		w[SEC_LSB +: 6]  = t.sec;
		w[MIN_LSB +: 6]  = t.min;
		w[HOUR_LSB +: 5] = t.hour;
		w[WDAY_LSB +: 3] = t.wday;
		return w;
	endfunction

	function automatic logic [DATA_W-1:0] date_word(input rtcca_time_t t);
		logic [DATA_W-1:0] w;
		w = '0;
		w[DAY_LSB +: 5]  = t.day;
		w[MON_LSB +: 4]  = t.mon;
		w[YEAR_LSB +: 7] = t.year;
		return w;
	endfunction

	function automatic rtcca_time_t set_time(input rtcca_time_t t, input logic [DATA_W-1:0] w);
		rtcca_time_t n;
		n      = t;
		n.sec  = w[SEC_LSB +: 6];
		n.min  = w[MIN_LSB +: 6];
		n.hour = w[HOUR_LSB +: 5];
		n.wday = w[WDAY_LSB +: 3];
		return n;
	endfunction

	function automatic rtcca_time_t set_date(input rtcca_time_t t, input logic [DATA_W-1:0] w);
		rtcca_time_t n;
		n      = t;
		n.day  = w[DAY_LSB +: 5];
		n.mon  = w[MON_LSB +: 4];
		n.year = w[YEAR_LSB +: 7];
		return n;
	endfunction

	// register read mux and address decode
	always_comb begin
		rbus.hit   = 1'b1;
		rbus.rdata = '0;
		case (rbus.addr)
			OFS_CFG: begin
				rbus.rdata[CFG_ON_BIT]      = st_ff.timer_on;
				rbus.rdata[CFG_SYNC_BIT]    = st_ff.rollover_sync_status;
				rbus.rdata[CAL_LSB +: 8]    = st_ff.cal;
			end
			OFS_ACFG: begin
				rbus.rdata[ACFG_EN_BIT]       = st_ff.alarm_enable;
				rbus.rdata[ACFG_INDEFINITE_REPEAT_BIT]    = st_ff.indefinite_repeat;
				rbus.rdata[ACFG_MSK_LSB +: 4] = st_ff.alarm_match_mask;
				rbus.rdata[ACFG_RPT_LSB +: 8] = st_ff.alarm_repeat_count;
			end
			OFS_TIME:  rbus.rdata = time_word(st_ff.now);
			OFS_DATE:  rbus.rdata = date_word(st_ff.now);
			OFS_ATIME: rbus.rdata = time_word(st_ff.alarm_compare_value);
			OFS_ADATE: rbus.rdata = date_word(st_ff.alarm_compare_value);
			OFS_STAT:  rbus.rdata[EV_N-1:0] = st_ff.stat;
			OFS_MASK:  rbus.rdata[EV_N-1:0] = st_ff.mask;
			default:   rbus.hit = 1'b0;
		endcase
	end

	always_comb begin
		logic                    fire;
		logic signed [PRE_W-1:0] cal_x4;
		logic [EV_N-1:0]         ev;
		fire    = 1'b0;
		cal_x4  = PRE_W'(signed'(st_ff.cal)) <<< CAL_SHIFT;
		ev      = '0;
		nxt_st  = st_ff;
		nxt_st.half_ev = 1'b0;
		nxt_st.full_ev = 1'b0;

		// timebase on crystal ticks
		if (xtal_tick & st_ff.timer_on) begin
			nxt_st.presc = st_ff.presc + PRE_W'(1);
			if (st_ff.presc == PRE_HALF) begin
				nxt_st.half_ev = 1'b1;
			end
			if (st_ff.presc == PRE_TOP) begin
				nxt_st.now     = advance(st_ff.now);
				nxt_st.full_ev = 1'b1;
				ev[EV_SEC]     = 1'b1;
				// minute boundary: negative start stretches, positive shortens
				nxt_st.presc   = (st_ff.now.sec == SEC_LAST) ? cal_x4 : '0;
			end
		end
		nxt_st.rollover_sync_status = st_ff.timer_on & (st_ff.presc >= PRE_SYNC);

		// alarm evaluation one cycle after the time update
		if (st_ff.alarm_enable) begin
			fire = (st_ff.half_ev & (st_ff.alarm_match_mask == MSK_HALF))
				| (st_ff.full_ev & alarm_match(st_ff.alarm_match_mask, st_ff.now,
					st_ff.alarm_compare_value));
		end
		if (fire) begin
			ev[EV_ALARM] = 1'b1;
			nxt_st.pulse = ~st_ff.pulse;
			if (st_ff.alarm_repeat_count != 8'h00) begin
				nxt_st.alarm_repeat_count = st_ff.alarm_repeat_count - 8'h01;
			end else if (st_ff.indefinite_repeat) begin
				nxt_st.alarm_repeat_count = RPT_ROLL;
			end else begin
				nxt_st.alarm_enable = 1'b0;
			end
		end

		// software writes take priority over the hardware update, except new status events
		if (rbus.wr_stb) begin
			case (rbus.addr)
				OFS_CFG: begin
					nxt_st.timer_on = rbus.wdata[CFG_ON_BIT];
					nxt_st.cal      = rbus.wdata[CAL_LSB +: 8];
				end
				OFS_ACFG: begin
					nxt_st.alarm_enable       = rbus.wdata[ACFG_EN_BIT];
					nxt_st.indefinite_repeat  = rbus.wdata[ACFG_INDEFINITE_REPEAT_BIT];
					nxt_st.alarm_match_mask   = rbus.wdata[ACFG_MSK_LSB +: 4];
					nxt_st.alarm_repeat_count = rbus.wdata[ACFG_RPT_LSB +: 8];
				end
				OFS_TIME: begin
					nxt_st.now   = set_time(st_ff.now, rbus.wdata);
					nxt_st.presc = '0;
				end
				OFS_DATE:  nxt_st.now = set_date(st_ff.now, rbus.wdata);
				OFS_ATIME: begin
					nxt_st.alarm_compare_value = set_time(st_ff.alarm_compare_value,
						rbus.wdata);
				end
				OFS_ADATE: begin
					nxt_st.alarm_compare_value = set_date(st_ff.alarm_compare_value,
						rbus.wdata);
				end
				OFS_STAT:  nxt_st.stat = st_ff.stat & ~rbus.wdata[EV_N-1:0];
				OFS_MASK:  nxt_st.mask = rbus.wdata[EV_N-1:0];
				default: begin
				end
			endcase
		end

		// new events win over a clear in the same cycle
		nxt_st.stat = nxt_st.stat | ev;
		nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign alarm_irq   = st_ff.irq;
	assign alarm_pulse = st_ff.pulse;
endmodule

// >>> logic/rtcca_pkg.sv
// rtcca_pkg: constants and types of the clock calibration and alarm block
//
// Operation
// - calibration signed, times four, applied each minute
// - negative removes pulses, positive adds pulses
// - enable bit 15 gates alarm, hardware clears it
// - mask field 13:10 selects matching digits
// - zero repeat without indefinite bit: one alarm
// - repeat count FFh gives 255 repetitions
// - decrement per alarm; at zero final alarm, disable
// - indefinite bit 14 rolls zero to FFh
// - every alarm event sets status bit 0; it raises an interrupt only while mask bit 0 is set
// - alarm pulse output toggles on each alarm
// - interval half second to one year, repeat options
package rtcca_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [ADDR_W-1:0] OFS_CFG   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ACFG  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TIME  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DATE  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ATIME = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ADATE = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_MASK  = 8'h1C;

	// clock_config_calib_register
	localparam int unsigned CFG_ON_BIT   = 15;
	localparam int unsigned CFG_SYNC_BIT = 12;
	localparam int unsigned CAL_LSB      = 0;
	// alarm_config_register
	localparam int unsigned ACFG_EN_BIT    = 15;
	localparam int unsigned ACFG_INDEFINITE_REPEAT_BIT = 14;
	localparam int unsigned ACFG_MSK_LSB   = 10;
	localparam int unsigned ACFG_RPT_LSB   = 0;
	// time and date words
	localparam int unsigned SEC_LSB  = 0;
	localparam int unsigned MIN_LSB  = 8;
	localparam int unsigned HOUR_LSB = 16;
	localparam int unsigned WDAY_LSB = 24;
	localparam int unsigned DAY_LSB  = 0;
	localparam int unsigned MON_LSB  = 8;
	localparam int unsigned YEAR_LSB = 16;
	// status and mask bits
	localparam int unsigned EV_N     = 2;
	localparam int unsigned EV_ALARM = 0;
	localparam int unsigned EV_SEC   = 1;

	localparam int unsigned XTAL_HZ    = 32768;
	localparam int unsigned SYNC_TICKS = 32;
	localparam int unsigned PRE_W      = 17;
	localparam logic signed [PRE_W-1:0] PRE_TOP  = PRE_W'(XTAL_HZ - 1);
	localparam logic signed [PRE_W-1:0] PRE_HALF = PRE_W'(XTAL_HZ / 2 - 1);
	localparam logic signed [PRE_W-1:0] PRE_SYNC = PRE_W'(XTAL_HZ - SYNC_TICKS);
	localparam int unsigned CAL_SHIFT  = 2;
	localparam logic [7:0]  RPT_ROLL   = 8'hFF;

	typedef logic [3:0] rtcca_alarm_match_mask_t;
	localparam rtcca_alarm_match_mask_t MSK_HALF  = 4'h0;
	localparam rtcca_alarm_match_mask_t MSK_SEC   = 4'h1;
	localparam rtcca_alarm_match_mask_t MSK_10SEC = 4'h2;
	localparam rtcca_alarm_match_mask_t MSK_MIN   = 4'h3;
	localparam rtcca_alarm_match_mask_t MSK_10MIN = 4'h4;
	localparam rtcca_alarm_match_mask_t MSK_HOUR  = 4'h5;
	localparam rtcca_alarm_match_mask_t MSK_DAY   = 4'h6;
	localparam rtcca_alarm_match_mask_t MSK_WEEK  = 4'h7;
	localparam rtcca_alarm_match_mask_t MSK_MONTH = 4'h8;
	localparam rtcca_alarm_match_mask_t MSK_YEAR  = 4'h9;

	typedef struct packed {
		logic [6:0] year;
		logic [3:0] mon;
		logic [4:0] day;
		logic [2:0] wday;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} rtcca_time_t;

	localparam rtcca_time_t TIME_RESET = '{mon: 4'h1, day: 5'h01, default: '0};
	localparam logic [5:0] SEC_LAST  = 6'h3B;
	localparam logic [5:0] MIN_LAST  = 6'h3B;
	localparam logic [4:0] HOUR_LAST = 5'h17;
	localparam logic [2:0] WDAY_LAST = 3'h6;
	localparam logic [3:0] MON_LAST  = 4'hC;
	localparam logic [6:0] YEAR_LAST = 7'h63;
	localparam logic [4:0] DAY_31    = 5'h1F;
	localparam logic [4:0] DAY_30    = 5'h1E;
	localparam logic [4:0] DAY_29    = 5'h1D;
	localparam logic [4:0] DAY_28    = 5'h1C;
	localparam logic [5:0] DIGIT_10  = 6'h0A;
endpackage

// >>> logic/rtcca_reg_if.sv
// rtcca_reg_if: register access strobes between the bus slave and the core
`timescale 1ns/1ps
interface rtcca_reg_if;
	import rtcca_pkg::*;
	logic              wr_stb;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              hit;
	modport bus  (output wr_stb, output addr, output wdata, input rdata, input hit);
	modport core (input wr_stb, input addr, input wdata, output rdata, output hit);
endinterface

// >>> logic/rtcca_xtal_sync.sv
// rtcca_xtal_sync: crystal clock pin synchroniser and rising-edge tick
`timescale 1ns/1ps
module rtcca_xtal_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic xtal_pin,
	output logic      tick
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
		logic tick;
	} rtcca_xs_t;

	rtcca_xs_t st_ff;
	rtcca_xs_t nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.meta = xtal_pin;
		nxt_st.sync = st_ff.meta;
		nxt_st.last = st_ff.sync;
		nxt_st.tick = st_ff.sync & ~st_ff.last;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;
endmodule

// >>> logic/rtcca_apb.sv
// rtcca_apb: zero-wait APB slave front end for the register file
`timescale 1ns/1ps
module rtcca_apb
	import rtcca_pkg::*;
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [rtcca_pkg::ADDR_W-1:0] paddr,
	input  wire logic [rtcca_pkg::DATA_W-1:0] pwdata,
	output logic [rtcca_pkg::DATA_W-1:0]      prdata,
	output logic                            pready,
	output logic                            pslverr,
	rtcca_reg_if.bus                        rbus
);
	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} rtcca_apb_t;

	rtcca_apb_t st_ff;
	rtcca_apb_t nxt_st;

	always_comb begin
		nxt_st        = st_ff;
		nxt_st.pready  = psel & ~penable;
		// error stands with pready only, never past the access cycle
		nxt_st.pslverr = psel & ~penable & ~rbus.hit;
		if (psel & ~penable) begin
			nxt_st.prdata  = (rbus.hit & ~pwrite) ? rbus.rdata : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rbus.addr   = paddr;
	assign rbus.wdata  = pwdata;
	assign rbus.wr_stb = psel & penable & st_ff.pready & pwrite & ~st_ff.pslverr;
	assign prdata      = st_ff.prdata;
	assign pready      = st_ff.pready;
	assign pslverr     = st_ff.pslverr;
endmodule

// >>> verif/rtcca_chk.sv
// rtcca_chk: port-level assertions for the calibration and alarm block
`timescale 1ns/1ps
module rtcca_chk
	import rtcca_pkg::*;
(
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [rtcca_pkg::ADDR_W-1:0] paddr,
	input wire logic [rtcca_pkg::DATA_W-1:0] pwdata,
	input wire logic [rtcca_pkg::DATA_W-1:0] prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire logic                         xtal_clk_pin,
	input wire logic                         alarm_irq,
	input wire logic                         alarm_pulse
);
	logic       wr_fire;
	logic [1:0] mask_sh_ff;
	logic [1:0] nxt_mask_sh;
	logic       en_sh_ff;
	logic       nxt_en_sh;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// shadows of the interrupt mask and alarm enable as software last wrote them
	assign wr_fire = psel && penable && pready && pwrite && !pslverr;
	always_comb begin
		nxt_mask_sh = mask_sh_ff;
		nxt_en_sh = en_sh_ff;
		if (wr_fire && paddr == OFS_MASK) begin
			nxt_mask_sh = pwdata[1:0];
		end
		if (wr_fire && paddr == OFS_ACFG) begin
			nxt_en_sh = pwdata[ACFG_EN_BIT];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_sh_ff <= 2'h0;
			en_sh_ff <= 1'b0;
		end else begin
			mask_sh_ff <= nxt_mask_sh;
			en_sh_ff <= nxt_en_sh;
		end
	end

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	sequence s_fire;
		$changed(alarm_pulse);
	endsequence

	chk_ready_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	chk_ready_single: assert property (s_access |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_zero: assert property (pslverr |-> pready && prdata == '0)
		else $error("error response malformed");
	chk_pulse_gated: assert property (s_fire |-> $past(en_sh_ff))
		else $error("alarm pulse toggled while alarm disabled");
	chk_pulse_spaced: assert property (s_fire |=> $stable(alarm_pulse)[*8])
		else $error("alarm pulse toggled twice in a row");
	chk_irq_on_alarm: assert property (s_fire ##0 mask_sh_ff[0] |-> ##[0:2] alarm_irq)
		else $error("unmasked alarm raised no interrupt");
	chk_irq_masked: assert property ((mask_sh_ff == 2'h0)[*3] |-> !alarm_irq)
		else $error("interrupt high with all sources masked");
	chk_irq_hold: assert property ($fell(alarm_irq) |-> $past(wr_fire))
		else $error("interrupt fell without a register write");
endmodule

bind rtcca_top rtcca_chk chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.xtal_clk_pin(xtal_clk_pin), .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse)
);

// >>> verif/tb.sv
// tb: register and alarm sequence bench for the calibration and alarm block
`timescale 1ns/1ps
module tb;
	import rtcca_pkg::*;
	localparam logic [7:0] CAL = 8'hFF;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              xtal_clk_pin = 1'b0;
	logic              alarm_irq;
	logic              alarm_pulse;
	logic [DATA_W-1:0] q;
	logic              e;
	int                error_cnt;
	int                checks_done;
	int                rise_cnt = 0;
	int                stamp [3];

	rtcca_top dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.xtal_clk_pin(xtal_clk_pin), .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// fastest crystal the synchroniser can follow: one rising edge every two cycles
	always @(posedge pclk) begin
		xtal_clk_pin <= ~xtal_clk_pin;
		if (!xtal_clk_pin) begin
			rise_cnt <= rise_cnt + 1;
		end
	end

	task automatic print_verdict;
		$display("mismatches %0d, checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			error_cnt++;
			$display("wrong value at %0t: no bus answer", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_word(q, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (3) @(posedge pclk);
	endtask

	task automatic wait_alarm(input int k);
		int   n;
		logic p;
		p = alarm_pulse;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (alarm_pulse === p && n < 40000);
		if (n >= 40000) begin
			error_cnt++;
			$display("wrong value at %0t: no alarm", $time);
		end
		stamp[k] = rise_cnt;
		repeat (3) @(posedge pclk);
	endtask

	initial begin
		repeat (120000) @(posedge pclk);
		error_cnt++;
		print_verdict;
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		error_cnt = 0;
		checks_done = 0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_CFG, 32'h0);
		rd(OFS_ACFG, 32'h0);
		rd(OFS_DATE, 32'h00000101);
		rd(OFS_ADATE, 32'h00000101);
		rd(OFS_STAT, 32'h0);
		rd(OFS_MASK, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk_bit(e, 1'b1);
		chk_word(q, 32'h0);
		apb(1'b1, 8'h20, 32'h5);
		chk_bit(e, 1'b1);
		// second 59 so the second alarm crosses a minute and reloads with calibration
		wr(OFS_MASK, 32'h1);
		wr(OFS_ATIME, 32'h00050000);
		rd(OFS_ATIME, 32'h00050000);
		wr(OFS_TIME, 32'h0000003B);
		wr(OFS_ACFG, 32'h00008001);
		wr(OFS_CFG, {16'h0, 8'h80, CAL});
		rd(OFS_CFG, {16'h0, 8'h80, CAL});
		wait_alarm(0);
		chk_bit(alarm_pulse, 1'b1);
		chk_bit(alarm_irq, 1'b1);
		rd(OFS_ACFG, 32'h00008000);
		wr(OFS_STAT, 32'h3);
		chk_bit(alarm_irq, 1'b0);
		// seconds-only match: alarm second 0 hits at the minute, hour ignored
		rd(OFS_CFG, {16'h0, 8'h80, CAL});
		wr(OFS_ACFG, 32'h0000CC00);
		wait_alarm(1);
		chk_bit(alarm_pulse, 1'b0);
		rd(OFS_ACFG, 32'h0000CCFF);
		rd(OFS_TIME, 32'h00000100);
		wr(OFS_MASK, 32'h0);
		wr(OFS_STAT, 32'h3);
		wr(OFS_ACFG, 32'h00008000);
		wait_alarm(2);
		chk_bit(alarm_pulse, 1'b1);
		chk_bit(alarm_irq, 1'b0);
		rd(OFS_ACFG, 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk_word(q & 32'h1, 32'h1);
		wr(OFS_MASK, 32'h1);
		chk_bit(alarm_irq, 1'b1);
		chk_word(32'(stamp[1] - stamp[0]), 32'd16384);
		chk_word(32'(stamp[2] - stamp[1]), 32'(16384 - 4 * int'($signed(CAL))));
		print_verdict;
	end
endmodule
